// ---- bench/adc_status_mode_regs_checker.sv ----
// Port-level assertions for the status and mode register bank
module adc_status_mode_regs_checker
    import adc_regs_pkg::*;
#(
    parameter int PULSE_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic link_clk_i,
    input wire logic cmd_valid_i,
    input adc_regs_pkg::cmd_type cmd_i,
    input wire logic cmd_ready_o,
    input wire logic rsp_valid_o,
    input wire logic [WORD_W-1:0] rsp_data_o,
    input wire logic sample_ready_o,
    input wire logic sample_ready_oe_o,
    input wire logic port_frozen_o,
    input wire logic map_check_en_o,
    input wire logic input_check_en_o,
    input wire logic poly_sel_o,
    input wire logic [1:0] word_size_sel_o,
    input wire logic timeout_en_o
);
    timeunit 1ns;
    timeprecision 100ps;
    cmd_type last_q;
    logic take, rd_st, rd_md;
    assign take = cmd_valid_i && cmd_ready_o;
    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) last_q <= '0;
        else if (take) last_q <= cmd_i;
    end
    assign rd_st = last_q.kind == CMD_READ && last_q.addr == ADDR_STATUS;
    assign rd_md = last_q.kind == CMD_READ && last_q.addr == ADDR_MODE;
    take_busy_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) take |=> !cmd_ready_o)
        else $error("ready stayed high after a command was taken");
    answer_time_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
        take |=> !rsp_valid_o [*3] ##[1:12] rsp_valid_o) else $error("answer missing or too early");
    rsp_ready_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) rsp_valid_o |-> cmd_ready_o)
        else $error("answer given while not ready");
    // Core-domain level, steady long before the bound runs out
    lock_set_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
        take && cmd_i.kind == CMD_LOCK |=> ##[0:12] port_frozen_o) else $error("lock not shown");
    unlock_clr_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
        take && cmd_i.kind == CMD_UNLOCK |=> ##[0:12] !port_frozen_o) else $error("unlock not shown");
    status_resv_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
        rsp_valid_o && rd_st |-> rsp_data_o[5:3] == 3'h0) else $error("reserved status bits set");
    status_mirror_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
        rsp_valid_o && rd_st |-> rsp_data_o[15] == port_frozen_o && rsp_data_o[11] == poly_sel_o
        && rsp_data_o[9:8] == word_size_sel_o) else $error("status fields differ from mode");
    mode_read_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i) rsp_valid_o && rd_md |->
        rsp_data_o == {2'h0, map_check_en_o, input_check_en_o, poly_sel_o, rsp_data_o[10], word_size_sel_o,
        3'h0, timeout_en_o, rsp_data_o[3:0]}) else $error("mode answer differs from mode outputs");
    pin_driven_a: assert property (@(posedge clk_i) disable iff (!nrst_i) !sample_ready_o |-> sample_ready_oe_o)
        else $error("ready pin low while floating");
    cover property (@(posedge link_clk_i) rsp_valid_o && rd_st);
    cover property (@(posedge link_clk_i) take && cmd_i.kind == CMD_LOCK);
    cover property (@(posedge clk_i) $fell(sample_ready_o));
endmodule : adc_status_mode_regs_checker
bind adc_status_mode_regs adc_status_mode_regs_checker #(.PULSE_CYCLES(PULSE_CYCLES)) checker_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .sample_ready_o(sample_ready_o), .sample_ready_oe_o(sample_ready_oe_o), .port_frozen_o(port_frozen_o),
    .map_check_en_o(map_check_en_o), .input_check_en_o(input_check_en_o), .poly_sel_o(poly_sel_o),
    .word_size_sel_o(word_size_sel_o), .timeout_en_o(timeout_en_o));

// ---- bench/adc_status_mode_regs_test.sv ----
// Self-checking bench for the status and mode register bank
module adc_status_mode_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_regs_pkg::*;
    localparam int PC = 2;
    logic clk = 0, lclk = 0, nrst = 0, cv, crdy, rv, pin, oe, frz, men, ien, poly, ten;
    logic [1:0] ws;
    logic [15:0] rd_data, mode_m;
    logic [2:0] done = 3'h0, en = 3'h7;
    fault_events_type ev = '0;
    cmd_type cmd;
    logic [15:0] expq[$];
    int errors = 0, samples_checked = 0, cycles = 0, seed = 32'h0089;
    initial forever #5 clk = ~clk;
    initial begin
        #3.7;
        forever #7.5 lclk = ~lclk;
    end
    adc_status_mode_regs #(.PULSE_CYCLES(PC)) dut (.clk_i(clk), .nrst_i(nrst), .link_clk_i(lclk),
        .cmd_valid_i(cv), .cmd_i(cmd), .cmd_ready_o(crdy), .rsp_valid_o(rv), .rsp_data_o(rd_data),
        .events_i(ev), .sample_done_i(done), .ch_enable_i(en), .sample_ready_o(pin),
        .sample_ready_oe_o(oe), .port_frozen_o(frz), .map_check_en_o(men), .input_check_en_o(ien),
        .poly_sel_o(poly), .word_size_sel_o(ws), .timeout_en_o(ten));
    link_host host (.link_clk_i(lclk), .cmd_ready_i(crdy), .rsp_valid_i(rv), .cmd_valid_o(cv), .cmd_o(cmd));
    task automatic summarize;
        if (errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (exp !== got) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask : check
    task automatic send(input cmd_kind_type k, input logic [5:0] a, input logic [15:0] w, input logic [15:0] e);
        expq.push_back(e);
        host.xfer(k, a, w);
    endtask : send
    function automatic logic [15:0] st(input logic [15:0] f);
        return f | (mode_m & 16'h0F00);
    endfunction : st
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        send(CMD_READ, a, 16'($random(seed)), e);
    endtask : rd
    task automatic wr(input logic [15:0] v);
        mode_m = v & MODE_STORE_MASK;
        send(CMD_WRITE, ADDR_MODE, mode_m, 16'h0000);
    endtask : wr
    task automatic pulse(input logic [2:0] d);
        @(negedge clk) done = d;
        @(negedge clk) done = 3'h0;
        repeat (3) @(negedge clk);
    endtask : pulse
    task automatic fire(input int i);
        @(negedge clk) ev = fault_events_type'(6'h20 >> i);
        @(negedge clk) ev = '0;
    endtask : fire
    always @(negedge lclk) begin
        if (rv === 1'b1) begin
            if (expq.size() == 0) check("spare answer", 16'hFFFF, rd_data);
            else check("answer", expq.pop_front(), rd_data);
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        int bits[6] = '{14, 13, 12, 7, 6, 6};
        int lows;
        logic [15:0] v, base;
        repeat (8) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        repeat (4) @(posedge lclk);
        mode_m = MODE_RESET;
        rd(ADDR_STATUS, 16'h0540);
        rd(ADDR_STATUS, 16'h0500);
        rd(ADDR_MODE, 16'h0510);
        rd(6'h03, 16'h0000);
        check("mode pins", 16'h0003, 16'({men, ien, poly, ws, ten}));
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            v[13:8] = {2'h3, i[0], 1'b0, i[1:0]};
            wr(v);
            rd(ADDR_MODE, mode_m);
            rd(ADDR_STATUS, st(16'h0));
            check("mode pins", 16'({mode_m[13:11], mode_m[9:8], mode_m[4]}), 16'({men, ien, poly, ws, ten}));
        end
        send(CMD_LOCK, 6'h0, 16'h0, 16'h0);
        rd(ADDR_STATUS, st(16'h8000));
        send(CMD_WRITE, ADDR_MODE, 16'h0, 16'h0);
        rd(ADDR_MODE, mode_m);
        check("frozen", 16'h1, 16'(frz));
        send(CMD_UNLOCK, 6'h0, 16'h0, 16'h0);
        rd(ADDR_STATUS, st(16'h0));
        for (int i = 0; i < 6; i++) begin
            fire(i);
            rd(ADDR_STATUS, st(16'h1 << bits[i]));
            rd(ADDR_STATUS, st(16'h0));
        end
        @(negedge clk) ev.trim_parity = 1'b1;
        rd(ADDR_STATUS, st(16'h0080));
        rd(ADDR_STATUS, st(16'h0080));
        @(negedge clk) ev.trim_parity = 1'b0;
        rd(ADDR_STATUS, st(16'h0080));
        wr(mode_m & 16'hCF00);
        fire(1);
        fire(2);
        rd(ADDR_STATUS, st(16'h0));
        base = mode_m;
        wr(base | 16'h0004);
        pulse(3'h2);
        check("pin", 16'h0, 16'(pin));
        rd(ADDR_STATUS, st(16'h0002));
        send(CMD_IDLE, 6'h0, 16'h0, st(16'h0002));
        check("pin", 16'h1, 16'(pin));
        wr(base);
        pulse(3'h1);
        check("pin", 16'h1, 16'(pin));
        pulse(3'h6);
        check("pin", 16'h0, 16'(pin));
        send(CMD_IDLE, 6'h0, 16'h0, st(16'h0007));
        wr(base | 16'h0002);
        check("drive", 16'h0, 16'(oe));
        wr(base | 16'h0009);
        lows = 0;
        @(negedge clk) done = 3'h4;
        @(negedge clk) done = 3'h0;
        repeat (12) @(negedge clk) lows += (pin === 1'b0);
        check("pulse", 16'(PC), 16'(lows));
        send(CMD_IDLE, 6'h0, 16'h0, st(16'h0004));
        send(CMD_RESET, 6'h0, 16'h0, 16'h0);
        mode_m = MODE_RESET;
        rd(ADDR_STATUS, 16'h0540);
        rd(ADDR_MODE, 16'h0510);
        repeat (4) @(posedge lclk);
        check("queue", 16'h0, 16'(expq.size()));
        summarize();
    end
endmodule : adc_status_mode_regs_test

// ---- bench/link_host.sv ----
// Host model that issues one command at a time on the link side
module link_host
    import adc_regs_pkg::*;
(
    input wire logic link_clk_i,
    input wire logic cmd_ready_i,
    input wire logic rsp_valid_i,
    output logic cmd_valid_o,
    output adc_regs_pkg::cmd_type cmd_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end
    task automatic xfer(input cmd_kind_type k, input logic [5:0] a, input logic [15:0] w);
        int n;
        n = 0;
        @(negedge link_clk_i);
        while (cmd_ready_i !== 1'b1 && n < 40) begin
            @(negedge link_clk_i);
            n++;
        end
        cmd_valid_o = 1'b1;
        cmd_o = '{k, a, w};
        @(posedge link_clk_i);
        @(negedge link_clk_i);
        cmd_valid_o = 1'b0;
        // Inverted stale word, so an old command never looks current
        cmd_o = ~cmd_o;
        while (rsp_valid_i !== 1'b1 && n < 80) begin
            @(negedge link_clk_i);
            n++;
        end
    endtask : xfer
endmodule : link_host

// ---- rtl/adc_status_mode_regs.sv ----
// Status and mode register bank with sample-ready pin control
module adc_status_mode_regs
    import adc_regs_pkg::*;
#(
    parameter int PULSE_CYCLES = READY_PULSE_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic link_clk_i,
    input wire logic cmd_valid_i,
    input adc_regs_pkg::cmd_type cmd_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [adc_regs_pkg::WORD_W-1:0] rsp_data_o,
    input adc_regs_pkg::fault_events_type events_i,
    input wire logic [adc_regs_pkg::NUM_CH-1:0] sample_done_i,
    input wire logic [adc_regs_pkg::NUM_CH-1:0] ch_enable_i,
    output logic sample_ready_o,
    output logic sample_ready_oe_o,
    output logic port_frozen_o,
    output logic map_check_en_o,
    output logic input_check_en_o,
    output logic poly_sel_o,
    output logic [1:0] word_size_sel_o,
    output logic timeout_en_o
);
    import adc_regs_pkg::*;

    localparam int PULSE_W = $clog2(PULSE_CYCLES + 1);

    typedef struct packed {
        logic ack;
        logic seen_req;
        logic [WORD_W-1:0] rsp;
        logic frozen;
        logic resync_seen;
        logic config_crc_fault;
        logic input_check_fault;
        logic reset_flag;
        logic trim_parity_fault;
        logic isolated_side_fault;
        logic [NUM_CH-1:0] new_sample;
        logic [WORD_W-1:0] mode;
        pin_state_type pin;
        logic [PULSE_W-1:0] pulse_cnt;
        logic ready_prev;
        logic pin_level;
        logic pin_oe;
    } core_type;

    localparam core_type CORE_INIT = '{
        mode: MODE_RESET & MODE_STORE_MASK,
        reset_flag: 1'b1,
        isolated_side_fault: 1'b1,
        pin: PIN_IDLE,
        pin_level: 1'b1,
        pin_oe: 1'b1,
        default: '0
    };

    core_type q;
    core_type d;
    logic rst_meta;
    logic rst_n;
    logic req_toggle;
    logic req_sync;
    cmd_type cmd_hold;
    logic cmd_go;
    logic status_read;
    logic data_read;
    logic write_ok;
    logic [NUM_CH-1:0] pending;
    logic ready_cond;
    logic ready_rise;
    logic resync_hit;
    logic map_fault_hit;
    logic input_fault_hit;
    logic trim_hit;
    logic iso_hit;

    function automatic logic [WORD_W-1:0] status_word(input core_type s);
        logic [WORD_W-1:0] w;
        w = '0;
        w[ST_LOCK] = s.frozen;
        w[ST_RESYNC] = s.resync_seen;
        w[ST_MAP_CRC] = s.config_crc_fault;
        w[ST_IN_CRC] = s.input_check_fault;
        w[ST_POLY] = s.mode[MD_POLY];
        w[ST_RESET] = s.reset_flag;
        w[ST_WSIZE+:2] = s.mode[MD_WSIZE+:2];
        w[ST_TRIM] = s.trim_parity_fault;
        w[ST_ISO] = s.isolated_side_fault;
        w[ST_NEW+:NUM_CH] = s.new_sample;
        return w;
    endfunction : status_word

    function automatic logic [WORD_W-1:0] mode_word(input core_type s);
        logic [WORD_W-1:0] w;
        w = s.mode;
        w[MD_RESET] = s.reset_flag;
        return w;
    endfunction : mode_word

    function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
        return a == target;
    endfunction : is_addr

    function automatic logic [WORD_W-1:0] read_word(input core_type s, input logic [ADDR_W-1:0] a);
        if (is_addr(a, ADDR_STATUS)) begin
            return status_word(s);
        end else if (is_addr(a, ADDR_MODE)) begin
            return mode_word(s);
        end else begin
            // Unmapped addresses answer zero rather than a neighbour
            return UNMAPPED_WORD;
        end
    endfunction : read_word

    // Lagging waits for every enabled channel; any and leading fire on the first
    function automatic logic ready_from(input logic [1:0] src, input logic [NUM_CH-1:0] pend,
            input logic [NUM_CH-1:0] en);
        logic hit;
        hit = 1'b0;
        case (src)
            SRC_LAGGING: begin
                hit = (|en) && (pend == en);
            end
            SRC_ANY: begin
                hit = |pend;
            end
            default: begin
                // Leading is the first pending channel, same as any at level granularity
                hit = |pend;
            end
        endcase
        return hit;
    endfunction : ready_from

    // Reset release is synchronous so no flop leaves reset on a split edge
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    link_cmd_port u_link (
        .link_clk_i(link_clk_i),
        .nrst_i(nrst_i),
        .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i),
        .cmd_ready_o(cmd_ready_o),
        .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o),
        .req_toggle_o(req_toggle),
        .cmd_hold_o(cmd_hold),
        .ack_toggle_i(q.ack),
        .rsp_word_i(q.rsp)
    );

    sync_agree #(.WIDTH(1)) u_req_sync (
        .clk_i(clk_i),
        .nrst_i(rst_n),
        .async_i(req_toggle),
        .sync_o(req_sync)
    );

    // Held command is stable while its toggle travels, so it is read directly
    assign cmd_go = req_sync != q.seen_req;

    always_comb begin
        status_read = 1'b0;
        data_read = 1'b0;
        write_ok = 1'b0;
        if (cmd_go) begin
            if (cmd_hold.kind == CMD_IDLE) begin
                // Idle frame returns status and also counts as the data read
                status_read = 1'b1;
                data_read = 1'b1;
            end else if (cmd_hold.kind == CMD_READ && is_addr(cmd_hold.addr, ADDR_STATUS)) begin
                status_read = 1'b1;
            end
            // Frozen port ignores writes and soft reset
            write_ok = !q.frozen;
        end
    end

    // A disabled channel never holds the pin
    for (genvar g = 0; g < NUM_CH; g++) begin : gen_pending
        assign pending[g] = q.new_sample[g] && ch_enable_i[g];
    end

    assign ready_cond = ready_from(q.mode[MD_SOURCE+:2], pending, ch_enable_i);

    // Event qualifiers; a check fault only counts while its check is enabled
    assign resync_hit = events_i.resync;
    assign map_fault_hit = events_i.map_check_fault && q.mode[MD_MAP_CRC_EN];
    assign input_fault_hit = events_i.input_check_fault && q.mode[MD_IN_CRC_EN];
    // A lasting parity fault is a level, so it returns after each clear
    assign trim_hit = events_i.trim_parity;
    assign iso_hit = events_i.supply_fault || events_i.barrier_error;

    assign ready_rise = ready_cond && !q.ready_prev;

    always_comb begin
        d = q;
        d.ready_prev = ready_cond;

        // Clears first so that a same-cycle event still sets
        if (status_read) begin
            d.resync_seen = 1'b0;
            d.config_crc_fault = 1'b0;
            d.input_check_fault = 1'b0;
            d.trim_parity_fault = 1'b0;
            d.isolated_side_fault = 1'b0;
        end
        if (data_read) begin
            d.new_sample = '0;
        end

        if (cmd_go) begin
            d.seen_req = req_sync;
            d.ack = req_sync;
            d.rsp = CMD_ACK_WORD;
            case (cmd_hold.kind)
                CMD_IDLE: begin
                    d.rsp = status_word(q);
                end
                CMD_READ: begin
                    d.rsp = read_word(q, cmd_hold.addr);
                end
                CMD_WRITE: begin
                    if (write_ok && is_addr(cmd_hold.addr, ADDR_MODE)) begin
                        // Reserved bits are not stored and read back zero
                        d.mode = cmd_hold.wdata & MODE_STORE_MASK;
                        if (!cmd_hold.wdata[MD_RESET]) begin
                            d.reset_flag = 1'b0;
                        end
                    end
                end
                CMD_LOCK: begin
                    d.frozen = 1'b1;
                end
                CMD_UNLOCK: begin
                    d.frozen = 1'b0;
                end
                CMD_RESET: begin
                    if (write_ok) begin
                        d = CORE_INIT;
                        d.seen_req = req_sync;
                        d.ack = req_sync;
                        d.rsp = CMD_ACK_WORD;
                        d.ready_prev = ready_cond;
                    end
                end
                default: begin
                    d.rsp = UNMAPPED_WORD;
                end
            endcase
        end

        // Event sets, winning over any clear above
        if (resync_hit) begin
            d.resync_seen = 1'b1;
        end
        if (map_fault_hit) begin
            d.config_crc_fault = 1'b1;
        end
        if (input_fault_hit) begin
            d.input_check_fault = 1'b1;
        end
        if (trim_hit) begin
            d.trim_parity_fault = 1'b1;
        end
        if (iso_hit) begin
            d.isolated_side_fault = 1'b1;
        end
        d.new_sample = d.new_sample | sample_done_i;

        case (q.pin)
            PIN_IDLE: begin
                if (ready_rise) begin
                    if (q.mode[MD_STYLE]) begin
                        d.pin = PIN_PULSE;
                        d.pulse_cnt = PULSE_W'(PULSE_CYCLES - 1);
                    end else begin
                        d.pin = PIN_LEVEL;
                    end
                end
            end
            PIN_LEVEL: begin
                if (!ready_cond) begin
                    d.pin = PIN_IDLE;
                end
            end
            PIN_PULSE: begin
                // Pulse runs its full length even if data are read early
                if (q.pulse_cnt == '0) begin
                    d.pin = PIN_IDLE;
                end else begin
                    d.pulse_cnt = q.pulse_cnt - 1'b1;
                end
            end
            default: begin
                d.pin = PIN_IDLE;
            end
        endcase

        d.pin_level = (d.pin == PIN_IDLE);
        d.pin_oe = !(d.pin == PIN_IDLE && d.mode[MD_FLOAT]);
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            q <= CORE_INIT;
        end else begin
            q <= d;
        end
    end

    assign sample_ready_o = q.pin_level;
    assign sample_ready_oe_o = q.pin_oe;
    assign port_frozen_o = q.frozen;
    assign map_check_en_o = q.mode[MD_MAP_CRC_EN];
    assign input_check_en_o = q.mode[MD_IN_CRC_EN];
    assign poly_sel_o = q.mode[MD_POLY];
    assign word_size_sel_o = q.mode[MD_WSIZE+:2];
    assign timeout_en_o = q.mode[MD_TIMEOUT];
endmodule : adc_status_mode_regs

// ---- rtl/link_cmd_port.sv ----
// Link-clock side of the command path: holds one command and waits for its answer
module link_cmd_port (
    input wire logic link_clk_i,
    input wire logic nrst_i,
    input wire logic cmd_valid_i,
    input adc_regs_pkg::cmd_type cmd_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [adc_regs_pkg::WORD_W-1:0] rsp_data_o,
    output logic req_toggle_o,
    output adc_regs_pkg::cmd_type cmd_hold_o,
    input wire logic ack_toggle_i,
    input wire logic [adc_regs_pkg::WORD_W-1:0] rsp_word_i
);
    import adc_regs_pkg::*;

    typedef struct packed {
        link_state_type state;
        logic req;
        cmd_type hold;
        logic rsp_valid;
        logic [WORD_W-1:0] rsp_data;
    } link_type;

    localparam link_type LINK_INIT = '{state: LINK_IDLE, hold: '{kind: CMD_IDLE, default: '0}, default: '0};

    link_type q;
    link_type d;
    logic rst_meta;
    logic rst_n;
    logic ack_sync;

    sync_agree #(.WIDTH(1)) u_ack_sync (
        .clk_i(link_clk_i),
        .nrst_i(rst_n),
        .async_i(ack_toggle_i),
        .sync_o(ack_sync)
    );

    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        case (q.state)
            LINK_IDLE: begin
                if (cmd_valid_i) begin
                    d.hold = cmd_i;
                    d.req = ~q.req;
                    d.state = LINK_WAIT;
                end
            end
            LINK_WAIT: begin
                // Answer word is settled long before the ack toggle arrives
                if (ack_sync == q.req) begin
                    d.rsp_data = rsp_word_i;
                    d.rsp_valid = 1'b1;
                    d.state = LINK_IDLE;
                end
            end
            default: begin
                d.state = LINK_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            q <= LINK_INIT;
        end else begin
            q <= d;
        end
    end

    assign cmd_ready_o = (q.state == LINK_IDLE);
    assign rsp_valid_o = q.rsp_valid;
    assign rsp_data_o = q.rsp_data;
    assign req_toggle_o = q.req;
    assign cmd_hold_o = q.hold;
endmodule : link_cmd_port

// ---- rtl/sync_agree.sv ----
// Three-stage synchroniser that accepts a change once stages two and three agree
module sync_agree #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } sync_state_type;

    sync_state_type q;
    sync_state_type d;
    logic [WIDTH-1:0] agree;

    // First stage feeds only the second
    assign agree = ~(q.s2 ^ q.s3);

    always_comb begin
        d.s1 = async_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.out = (q.s3 & agree) | (q.out & ~agree);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.out;
endmodule : sync_agree

// ---- shared/adc_regs_pkg.sv ----
// Constants and types for the status and mode register bank
package adc_regs_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int READY_PULSE_NS = 40;
    localparam int READY_PULSE_CYCLES = (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NUM_CH = 3;
    localparam int ADDR_W = 6;
    localparam int WORD_W = 16;
    localparam logic [5:0] ADDR_STATUS = 6'h01;
    localparam logic [5:0] ADDR_MODE = 6'h02;
    localparam logic [15:0] STATUS_RESET = 16'h0540;
    localparam logic [15:0] MODE_RESET = 16'h0510;
    localparam logic [15:0] MODE_STORE_MASK = 16'h3B1F;
    localparam logic [15:0] UNMAPPED_WORD = 16'h0000;
    localparam logic [15:0] CMD_ACK_WORD = 16'h0000;
    localparam int ST_LOCK = 15;
    localparam int ST_RESYNC = 14;
    localparam int ST_MAP_CRC = 13;
    localparam int ST_IN_CRC = 12;
    localparam int ST_POLY = 11;
    localparam int ST_RESET = 10;
    localparam int ST_WSIZE = 8;
    localparam int ST_TRIM = 7;
    localparam int ST_ISO = 6;
    localparam int ST_NEW = 0;
    localparam int MD_MAP_CRC_EN = 13;
    localparam int MD_IN_CRC_EN = 12;
    localparam int MD_POLY = 11;
    localparam int MD_RESET = 10;
    localparam int MD_WSIZE = 8;
    localparam int MD_TIMEOUT = 4;
    localparam int MD_SOURCE = 2;
    localparam int MD_FLOAT = 1;
    localparam int MD_STYLE = 0;
    localparam logic [1:0] SRC_LAGGING = 2'h0;
    localparam logic [1:0] SRC_ANY = 2'h1;

    typedef enum logic [5:0] {
        CMD_IDLE = 6'b000001,
        CMD_READ = 6'b000010,
        CMD_WRITE = 6'b000100,
        CMD_LOCK = 6'b001000,
        CMD_UNLOCK = 6'b010000,
        CMD_RESET = 6'b100000
    } cmd_kind_type;

    typedef struct packed {
        cmd_kind_type kind;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } cmd_type;

    typedef struct packed {
        logic resync;
        logic map_check_fault;
        logic input_check_fault;
        logic trim_parity;
        logic supply_fault;
        logic barrier_error;
    } fault_events_type;

    typedef enum logic [2:0] {
        PIN_IDLE = 3'b001,
        PIN_LEVEL = 3'b010,
        PIN_PULSE = 3'b100
    } pin_state_type;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b01,
        LINK_WAIT = 2'b10
    } link_state_type;
endpackage : adc_regs_pkg
